// File: core/rssm_defines.vh
`ifndef RSSM_DEFINES_VH
`define RSSM_DEFINES_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define RSSM_ADDR_MON        8'hff
`define RSSM_ADDR_CAUSE      8'hef

// ----------------------------------------
// supply monitor control fields
// ----------------------------------------
`define RSSM_MON_ON          7
`define RSSM_MON_RST_OK      6
`define RSSM_MON_WARN_OK     5
`define RSSM_MON_BAT_OK      4
`define RSSM_MON_CORE_IE     3
`define RSSM_MON_BAT_IE      2
`define RSSM_MON_UNUSED      2'h0

// ----------------------------------------
// reset cause fields
// ----------------------------------------
`define RSSM_CAUSE_PIN       0
`define RSSM_CAUSE_POWER     1
`define RSSM_CAUSE_MCD       2
`define RSSM_CAUSE_WDT       3
`define RSSM_CAUSE_CMP       5

// ----------------------------------------
// reset values
// ----------------------------------------
`define RSSM_RST_MON_ON      1'b1
`define RSSM_RST_MON_SEL     1'b1
`define RSSM_RST_CORE_IE     1'b1
`define RSSM_RST_BAT_IE      1'b0
`define RSSM_RST_MCD_EN      1'b0
`define RSSM_RST_CMP_EN      1'b0
`define RSSM_RST_WDT_EN      1'b1
`define RSSM_RDATA_ZERO      8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define RSSM_CLK_MHZ         25
`define RSSM_MCD_TIME_US     100
`define RSSM_WDT_DIV         12
`define RSSM_RESET_HOLD      4

`endif

// File: core/rssm_clock_monitor.v
`timescale 1ns/10ps
`include "rssm_defines.vh"

module rssm_clock_monitor #(
  parameter CNT_W = 12
) (
  // clock and reset
  input  wire             clk_in,
  input  wire             rst_in,
  // control
  input  wire             enable_in,
  input  wire             sys_clk_in,
  // result
  output wire             timeout_out
);

  // ----------------------------------------
  // limit
  // ----------------------------------------
  localparam integer     MCD_CYCLES = `RSSM_MCD_TIME_US * `RSSM_CLK_MHZ;
  localparam [CNT_W-1:0] LIMIT      = MCD_CYCLES[CNT_W-1:0];
  localparam [CNT_W-1:0] ONE        = {{(CNT_W-1){1'b0}}, 1'b1};

  reg             prev_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg             fire_reg;
  wire            edge_seen;

  assign edge_seen   = prev_reg ^ sys_clk_in;
  assign timeout_out = fire_reg;

  // ----------------------------------------
  // stuck level counter
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (rst_in || !enable_in) begin
      prev_reg <= 1'b0;
      cnt_reg  <= {CNT_W{1'b0}};
      fire_reg <= 1'b0;
    end else begin
      prev_reg <= sys_clk_in;
      fire_reg <= 1'b0;
      if (edge_seen) begin
        cnt_reg <= {CNT_W{1'b0}};
      end else if (cnt_reg != LIMIT) begin
        cnt_reg <= cnt_reg + ONE;
      end else begin
        fire_reg <= 1'b1;
        cnt_reg  <= {CNT_W{1'b0}};
      end
    end
  end

endmodule

// File: core/rssm_reset_source.v
// Contract
// - monitor on bit 7 switches supply monitor; resets only when also selected.
// - bit 6 reads live core supply above reset threshold.
// - bit 5 reads live core supply above warning threshold.
// - bit 4 reads battery above warning; present only on some variants.
// - bit 3 enables core warning interrupt; reads 1 where absent.
// - bit 2 enables battery warning interrupt; held 0 where absent.
// - bits 1:0 read 00b, writes ignored.
// - pin reset keeps working in suspend and sleep.
// - pin reset sets cause bit 0 on exit.
// - clock stuck high or low over 100 us causes reset.
// - cause bit 2 writes detector enable, reads missing clock flag.
// - missing clock reset gated in suspend/sleep, enable kept.
// - detector, comparator and watchdog resets never drive the pin.
// - writing 1 to cause bit 5 selects comparator reset.
// - selected comparator with low output resets device; reset deselects comparator.
// - cause bit 5 reads 1 only after comparator reset.
// - comparator reset in low power only if comparator wakes.
// - watchdog enabled, ticked by clock divided by 12 after reset.
// - unserviced watchdog resets and sets watchdog flag.
// - watchdog reset gated in suspend/sleep, enable kept.
// - power resets enable and select the supply monitor.
`timescale 1ns/10ps
`include "rssm_defines.vh"

module rssm_reset_source #(
  parameter HAS_BATTERY = 1,
  parameter WDT_W       = 8,
  parameter WDT_TICKS   = 255,
  parameter MCD_CNT_W   = 12
) (
  // clock and power-on reset
  input  wire       clk_in,
  input  wire       rst_in,
  // register port
  input  wire [7:0] sfr_addr_in,
  input  wire       sfr_wr_in,
  input  wire       sfr_rd_in,
  input  wire [7:0] sfr_wdata_in,
  output wire [7:0] sfr_rdata_out,
  // external reset pin
  input  wire       rst_pin_in,
  output wire       rst_pin_out,
  output wire       rst_pin_oe_out,
  // analog status
  input  wire       vdd_above_reset_in,
  input  wire       vdd_above_warn_in,
  input  wire       vbat_above_warn_in,
  input  wire       cmp_out_in,
  input  wire       cmp_wake_in,
  // system clock sample and power modes
  input  wire       sys_clk_in,
  input  wire       suspend_in,
  input  wire       sleep_in,
  // watchdog control
  input  wire       wdt_service_in,
  input  wire       wdt_disable_in,
  // results
  output wire       sys_reset_out,
  output wire       core_warning_irq_out,
  output wire       battery_warning_irq_out
);

  // ----------------------------------------
  // constants
  // ----------------------------------------
  localparam integer     HOLD_I    = `RSSM_RESET_HOLD;
  localparam integer     DIV_I     = `RSSM_WDT_DIV - 1;
  localparam [2:0]       HOLD      = HOLD_I[2:0];
  localparam [3:0]       DIV_LAST  = DIV_I[3:0];
  localparam [WDT_W-1:0] WDT_LIMIT = WDT_TICKS[WDT_W-1:0];
  localparam [WDT_W-1:0] WDT_ONE   = {{(WDT_W-1){1'b0}}, 1'b1};

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg             mon_on_reg;
  reg             mon_sel_reg;
  reg             core_ie_reg;
  reg             bat_ie_reg;
  reg             mcd_en_reg;
  reg             cmp_en_reg;
  reg             wdt_en_reg;
  reg [3:0]       div_reg;
  reg [WDT_W-1:0] wdt_cnt_reg;
  reg             wdt_fire_reg;
  reg [2:0]       hold_reg;
  reg             in_reset_reg;
  reg             power_flag_reg;
  reg             pin_flag_reg;
  reg             mcd_flag_reg;
  reg             wdt_flag_reg;
  reg             cmp_flag_reg;
  reg [7:0]       rdata_reg;
  reg [7:0]       rdata_next;

  // ----------------------------------------
  // flag update helper
  // ----------------------------------------
  function next_flag;
    input old_flag;
    input src;
    input entry;
    begin
      if (entry) begin
        next_flag = src;
      end else begin
        next_flag = old_flag | src;
      end
    end
  endfunction

  // ----------------------------------------
  // source conditions
  // ----------------------------------------
  wire low_power;
  wire mcd_timeout;
  wire src_pin;
  wire src_power;
  wire src_mcd;
  wire src_cmp;
  wire src_wdt;
  wire src_any;
  wire entry;
  wire wr_mon;
  wire wr_cause;
  wire tick;

  assign low_power = suspend_in | sleep_in;
  assign src_pin   = ~rst_pin_in;
  assign src_power = mon_on_reg & mon_sel_reg & ~vdd_above_reset_in & ~sleep_in;
  assign src_mcd   = mcd_timeout;
  assign src_cmp   = cmp_en_reg & ~cmp_out_in & (~low_power | cmp_wake_in);
  assign src_wdt   = wdt_fire_reg;
  assign src_any   = src_pin | src_power | src_mcd | src_cmp | src_wdt;
  assign entry     = ~in_reset_reg;

  assign wr_mon    = sfr_wr_in & ~in_reset_reg & (sfr_addr_in == `RSSM_ADDR_MON);
  assign wr_cause  = sfr_wr_in & ~in_reset_reg & (sfr_addr_in == `RSSM_ADDR_CAUSE);
  assign tick      = (div_reg == DIV_LAST);

  // ----------------------------------------
  // missing clock detector
  // ----------------------------------------
  rssm_clock_monitor #(
    .CNT_W       (MCD_CNT_W)
  ) u_clock_monitor (
    .clk_in      (clk_in),
    .rst_in      (rst_in | in_reset_reg),
    .enable_in   (mcd_en_reg & ~low_power),
    .sys_clk_in  (sys_clk_in),
    .timeout_out (mcd_timeout)
  );

  // ----------------------------------------
  // reset state and hold
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      in_reset_reg <= 1'b1;
      hold_reg     <= HOLD;
    end else if (src_any) begin
      in_reset_reg <= 1'b1;
      hold_reg     <= HOLD;
    end else if (hold_reg != 3'h0) begin
      in_reset_reg <= 1'b1;
      hold_reg     <= hold_reg - 3'h1;
    end else begin
      in_reset_reg <= 1'b0;
    end
  end

  assign sys_reset_out  = in_reset_reg;
  assign rst_pin_out    = 1'b0;
  assign rst_pin_oe_out = rst_in | src_power;

  // ----------------------------------------
  // cause flags
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      power_flag_reg <= 1'b1;
      pin_flag_reg   <= 1'b0;
      mcd_flag_reg   <= 1'b0;
      wdt_flag_reg   <= 1'b0;
      cmp_flag_reg   <= 1'b0;
    end else if (src_any) begin
      power_flag_reg <= next_flag(power_flag_reg, src_power, entry);
      if (src_power || (!entry && power_flag_reg)) begin
        pin_flag_reg <= 1'b0;
        mcd_flag_reg <= 1'b0;
        wdt_flag_reg <= 1'b0;
        cmp_flag_reg <= 1'b0;
      end else begin
        pin_flag_reg <= next_flag(pin_flag_reg, src_pin, entry);
        mcd_flag_reg <= next_flag(mcd_flag_reg, src_mcd, entry);
        wdt_flag_reg <= next_flag(wdt_flag_reg, src_wdt, entry);
        cmp_flag_reg <= next_flag(cmp_flag_reg, src_cmp, entry);
      end
    end
  end

  // ----------------------------------------
  // supply monitor enable and select
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      mon_on_reg  <= `RSSM_RST_MON_ON;
      mon_sel_reg <= `RSSM_RST_MON_SEL;
    end else if (src_power) begin
      mon_on_reg  <= `RSSM_RST_MON_ON;
      mon_sel_reg <= `RSSM_RST_MON_SEL;
    end else begin
      if (wr_mon) begin
        mon_on_reg <= sfr_wdata_in[`RSSM_MON_ON];
      end
      if (wr_cause) begin
        mon_sel_reg <= sfr_wdata_in[`RSSM_CAUSE_POWER];
      end
    end
  end

  // ----------------------------------------
  // interrupt enables and source enables
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (rst_in || in_reset_reg) begin
      core_ie_reg <= `RSSM_RST_CORE_IE;
      bat_ie_reg  <= `RSSM_RST_BAT_IE;
      mcd_en_reg  <= `RSSM_RST_MCD_EN;
      cmp_en_reg  <= `RSSM_RST_CMP_EN;
    end else begin
      if (wr_mon) begin
        core_ie_reg <= sfr_wdata_in[`RSSM_MON_CORE_IE];
        bat_ie_reg  <= sfr_wdata_in[`RSSM_MON_BAT_IE];
      end
      if (wr_cause) begin
        mcd_en_reg <= sfr_wdata_in[`RSSM_CAUSE_MCD];
        cmp_en_reg <= sfr_wdata_in[`RSSM_CAUSE_CMP];
      end
    end
  end

  // ----------------------------------------
  // warning interrupts
  // ----------------------------------------
  wire core_ie_eff;
  wire bat_ie_eff;

  assign core_ie_eff = (HAS_BATTERY != 0) ? core_ie_reg : 1'b1;
  assign bat_ie_eff  = (HAS_BATTERY != 0) ? bat_ie_reg : 1'b0;
  assign core_warning_irq_out    = core_ie_eff & ~vdd_above_warn_in & ~in_reset_reg;
  assign battery_warning_irq_out = bat_ie_eff & ~vbat_above_warn_in & ~in_reset_reg;

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  always @(posedge clk_in) begin
    if (rst_in || in_reset_reg) begin
      wdt_en_reg   <= `RSSM_RST_WDT_EN;
      div_reg      <= 4'h0;
      wdt_cnt_reg  <= {WDT_W{1'b0}};
      wdt_fire_reg <= 1'b0;
    end else begin
      wdt_fire_reg <= 1'b0;
      div_reg      <= tick ? 4'h0 : div_reg + 4'h1;
      if (wdt_disable_in) begin
        wdt_en_reg <= 1'b0;
      end
      if (wdt_service_in || !wdt_en_reg) begin
        wdt_cnt_reg <= {WDT_W{1'b0}};
      end else if (tick && !low_power) begin
        if (wdt_cnt_reg == WDT_LIMIT) begin
          wdt_fire_reg <= 1'b1;
          wdt_cnt_reg  <= {WDT_W{1'b0}};
        end else begin
          wdt_cnt_reg <= wdt_cnt_reg + WDT_ONE;
        end
      end
    end
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  always @* begin
    rdata_next = `RSSM_RDATA_ZERO;
    if (sfr_addr_in == `RSSM_ADDR_MON) begin
      rdata_next[`RSSM_MON_ON]      = mon_on_reg;
      rdata_next[`RSSM_MON_RST_OK]  = vdd_above_reset_in;
      rdata_next[`RSSM_MON_WARN_OK] = vdd_above_warn_in;
      rdata_next[`RSSM_MON_BAT_OK]  = (HAS_BATTERY != 0) & vbat_above_warn_in;
      rdata_next[`RSSM_MON_CORE_IE] = core_ie_eff;
      rdata_next[`RSSM_MON_BAT_IE]  = bat_ie_eff;
      rdata_next[1:0]               = `RSSM_MON_UNUSED;
    end else if (sfr_addr_in == `RSSM_ADDR_CAUSE) begin
      rdata_next[`RSSM_CAUSE_PIN]   = pin_flag_reg;
      rdata_next[`RSSM_CAUSE_POWER] = power_flag_reg;
      rdata_next[`RSSM_CAUSE_MCD]   = mcd_flag_reg;
      rdata_next[`RSSM_CAUSE_WDT]   = wdt_flag_reg;
      rdata_next[`RSSM_CAUSE_CMP]   = cmp_flag_reg;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      rdata_reg <= `RSSM_RDATA_ZERO;
    end else if (sfr_rd_in) begin
      rdata_reg <= rdata_next;
    end
  end

  assign sfr_rdata_out = rdata_reg;

endmodule

// File: dv/rssm_checker_assertions.sv
`timescale 1ns/10ps
module rssm_checker (
  // clock and reset
  input wire       clk_in,
  input wire       rst_in,
  // watched ports
  input wire [7:0] sfr_addr_in,
  input wire       sfr_rd_in,
  input wire [7:0] sfr_rdata_out,
  input wire       rst_pin_in,
  input wire       rst_pin_out,
  input wire       rst_pin_oe_out,
  input wire       vdd_above_reset_in,
  input wire       vdd_above_warn_in,
  input wire       vbat_above_warn_in,
  input wire       sys_reset_out,
  input wire       core_warning_irq_out,
  input wire       battery_warning_irq_out
);
  // ----------------------------------------
  // port checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  wire mon_rd = sfr_rd_in && sfr_addr_in == 8'hff;

  chk_pin_resets: assert property (
    !rst_pin_in |=> sys_reset_out) else $error("pin low without reset");
  chk_unused_zero: assert property (
    mon_rd |=> sfr_rdata_out[1:0] == 2'b00) else $error("unused bits not zero");
  chk_status_live: assert property (
    mon_rd |=> sfr_rdata_out[6] == $past(vdd_above_reset_in)) else $error("bad reset status");
  chk_warn_live: assert property (
    mon_rd |=> sfr_rdata_out[5] == $past(vdd_above_warn_in)) else $error("bad warn status");
  chk_battery_live: assert property (
    mon_rd |=> sfr_rdata_out[4] == $past(vbat_above_warn_in)) else $error("bad battery");
  chk_pin_undriven: assert property (
    !rst_in && vdd_above_reset_in |-> !rst_pin_oe_out) else $error("pin driven");
  chk_pin_pulls_low: assert property (
    rst_pin_oe_out |-> !rst_pin_out) else $error("pin driven high");
  chk_core_irq_cause: assert property (
    core_warning_irq_out |-> !vdd_above_warn_in && !sys_reset_out) else $error("core irq");
  chk_bat_irq_cause: assert property (
    battery_warning_irq_out |-> !vbat_above_warn_in && !sys_reset_out) else $error("bat irq");
  chk_release_hold: assert property (
    $fell(rst_in) |-> sys_reset_out[*3]) else $error("reset released early");
endmodule

bind rssm_reset_source rssm_checker chk (.clk_in, .rst_in, .sfr_addr_in, .sfr_rd_in,
  .sfr_rdata_out, .rst_pin_in, .rst_pin_out, .rst_pin_oe_out, .vdd_above_reset_in,
  .vdd_above_warn_in, .vbat_above_warn_in, .sys_reset_out, .core_warning_irq_out,
  .battery_warning_irq_out);

// File: dv/rssm_far_side.sv
`timescale 1ns/10ps
module rssm_far_side (
  // clock and commands
  input  wire logic clk_in,
  input  wire logic run_in,
  input  wire logic pull_low_in,
  // device pin
  input  wire logic pin_drv_in,
  input  wire logic pin_oe_in,
  // outputs
  output logic      pin_out,
  output logic      sys_clk_out
);
  // ----------------------------------------
  // pulled-up pin, low wins
  // ----------------------------------------
  assign pin_out = ~(pull_low_in | (pin_oe_in & ~pin_drv_in));
  initial sys_clk_out = 1'b0;
  always @(negedge clk_in) begin
    if (run_in) sys_clk_out <= ~sys_clk_out;
  end
endmodule

// File: dv/test_reset_source_supply_monitor.sv
`timescale 1ns/10ps
module test_reset_source_supply_monitor;
  logic       clk_in = 0, rst_in = 1, sfr_wr_in = 0, sfr_rd_in = 0, rst_pin_in;
  logic [7:0] sfr_addr_in = 0, sfr_wdata_in = 0, sfr_rdata_out, d;
  logic       vdd_above_reset_in = 1, vdd_above_warn_in = 1, vbat_above_warn_in = 1;
  logic       cmp_out_in = 1, cmp_wake_in = 0, sys_clk_in, suspend_in = 0, sleep_in = 0;
  logic       wdt_service_in = 0, wdt_disable_in = 1, rst_pin_out, rst_pin_oe_out;
  logic       sys_reset_out, core_warning_irq_out, battery_warning_irq_out;
  logic       pull_low = 0, clk_run = 1, rd_seen = 0;
  logic [7:0] exp_q[$];
  int         fail_count = 0;
  int         samples_checked = 0;

  initial forever #20 clk_in = ~clk_in;
  rssm_reset_source #(.WDT_TICKS(3)) uut (
    .clk_in, .rst_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out,
    .rst_pin_in, .rst_pin_out, .rst_pin_oe_out, .vdd_above_reset_in, .vdd_above_warn_in,
    .vbat_above_warn_in, .cmp_out_in, .cmp_wake_in, .sys_clk_in, .suspend_in, .sleep_in,
    .wdt_service_in, .wdt_disable_in, .sys_reset_out, .core_warning_irq_out,
    .battery_warning_irq_out);
  rssm_far_side far (.clk_in, .run_in(clk_run), .pull_low_in(pull_low),
    .pin_drv_in(rst_pin_out), .pin_oe_in(rst_pin_oe_out), .pin_out(rst_pin_in),
    .sys_clk_out(sys_clk_in));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_in);
    sfr_addr_in = a;
    sfr_wdata_in = v;
    sfr_wr_in = 1;
    @(negedge clk_in);
    sfr_wr_in = 0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_in);
    sfr_addr_in = a;
    sfr_rd_in = 1;
    exp_q.push_back(e);
    @(negedge clk_in);
    sfr_rd_in = 0;
  endtask
  task automatic expect_rst(input int lim, input logic e);
    int n;
    n = 0;
    while (sys_reset_out !== 1'b1 && n < lim) begin
      @(negedge clk_in);
      n++;
    end
    cmp({7'h0, sys_reset_out}, {7'h0, e});
  endtask
  task automatic settle;
    while (sys_reset_out !== 1'b0) @(negedge clk_in);
    repeat (2) @(negedge clk_in);
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_in) rd_seen <= sfr_rd_in;
  always @(negedge clk_in) begin
    if (rd_seen) cmp(sfr_rdata_out, exp_q.pop_front());
  end
  initial begin
    #600000;
    fail_count++;
    tally_and_finish;
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    d = 8'($urandom(21));
    repeat (12) @(negedge clk_in);
    rst_in = 0;
    settle;
    rd_reg(8'hef, 8'h02);
    rd_reg(8'hff, 8'hf8);
    rd_reg(8'h10, 8'h00);
    repeat (8) begin
      d = 8'($urandom);
      {vdd_above_warn_in, vbat_above_warn_in} = 2'($urandom);
      wr_reg(8'hff, d);
      rd_reg(8'hff, {d[7], 1'b1, vdd_above_warn_in, vbat_above_warn_in, d[3:2], 2'b00});
      cmp({6'h0, core_warning_irq_out, battery_warning_irq_out},
          {6'h0, d[3] & ~vdd_above_warn_in, d[2] & ~vbat_above_warn_in});
    end
    {vdd_above_warn_in, vbat_above_warn_in} = 2'b11;
    wr_reg(8'hff, 8'h04);
    vdd_above_reset_in = 0;
    expect_rst(20, 0);
    rd_reg(8'hff, 8'h34);
    vdd_above_reset_in = 1;
    wr_reg(8'hff, 8'h84);
    vdd_above_reset_in = 0;
    expect_rst(5, 1);
    wdt_disable_in = 0;
    vdd_above_reset_in = 1;
    settle;
    rd_reg(8'hef, 8'h02);
    rd_reg(8'hff, 8'hf8);
    expect_rst(80, 1);
    settle;
    rd_reg(8'hef, 8'h08);
    suspend_in = 1;
    expect_rst(150, 0);
    suspend_in = 0;
    expect_rst(80, 1);
    settle;
    repeat (4) begin
      wdt_service_in = 1;
      @(negedge clk_in);
      wdt_service_in = 0;
      expect_rst(30, 0);
    end
    wdt_disable_in = 1;
    sleep_in = 1;
    pull_low = 1;
    expect_rst(5, 1);
    pull_low = 0;
    sleep_in = 0;
    settle;
    rd_reg(8'hef, 8'h01);
    wr_reg(8'hef, 8'h22);
    sleep_in = 1;
    cmp_out_in = 0;
    expect_rst(20, 0);
    cmp_wake_in = 1;
    expect_rst(5, 1);
    cmp_out_in = 1;
    sleep_in = 0;
    settle;
    rd_reg(8'hef, 8'h20);
    wr_reg(8'hef, 8'h06);
    suspend_in = 1;
    clk_run = 0;
    expect_rst(2700, 0);
    clk_run = 1;
    suspend_in = 0;
    repeat (4) @(negedge clk_in);
    clk_run = 0;
    expect_rst(2400, 0);
    expect_rst(200, 1);
    clk_run = 1;
    settle;
    rd_reg(8'hef, 8'h04);
    repeat (3) @(negedge clk_in);
    tally_and_finish;
  end
endmodule
